// ===== ldp_player.sv
`timescale 1ns/1ps
`include "ldp_map.svh"
// Summary of operation
// R1 - pattern must be fully loaded before playback may start
// R2 - once started, the stored pattern loops forever until stopped
// R3 - board reset or a second start stops the looping output
// R4 - length 4096 to 512M samples, multiple of 32, is accepted; the code also caps it at 1 << AW rows, so only 4096 at the default AW of 12
// R5 - preamble plays once; each repeat restarts after the preamble
// R6 - loop restart drives an 8 sample-cycle high marker pulse
// R7 - continuous auxiliary clock at sample rate divided by 16
// R8 - host supplies samples within the signed range of the resolution
// R9 - one, two or four channels, each to its own converter lane
// R10 - format selects two's complement or offset binary output coding
// R11 - host applies scaling to samples before delivery
// R12 - transmit fifo overflow is flagged as a visible error
// R13 - samples, marker and divided clock run in the sample clock domain
module ldp_player #(
    parameter int AW = 12,
    parameter int RES = 16,
    parameter int LANES = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter side
    input wire logic sample_en,
    input wire logic lane_ready,
    output logic [LANES*RES-1:0] lane_data,
    output logic lane_valid,
    output logic loop_restart_marker,
    output logic sample_rate_div_clock,
    // indicators
    output logic board_indicator_lamp,
    output logic irq
);
    localparam int DW = LANES * RES;

    // row packing is fixed at four lanes; indices are 32 bits wide
    if (LANES != 4 || RES < 2 || RES > 32 || AW < 2 || AW > 29) begin : g_bad_param
        $error("ldp_player: unsupported parameters");
    end

    ldp_pkg::ldp_state_e state_r;
    ldp_pkg::ldp_cfg_s cfg_r;
    ldp_pkg::ldp_evt_s evt;
    logic [31:0] len_r, pre_r, waddr_r, loops_r;
    logic [2:0] isr_r, imr_r;
    logic loaded_r, ovf_r;
    logic [RES-1:0] wstage_r [0:LANES-1];
    logic [1:0] wlane_r;
    logic [31:0] rd_idx_r;
    logic [3:0] mark_cnt_r;
    logic [3:0] div_cnt_r;
    logic rvalid_r;
    logic [DW-1:0] mem_rdata;
    logic wr_en, rd_en, setup_ok, mem_we;
    logic start_req, reset_req;
    logic [DW-1:0] wrow;

    // apb answers in the access phase with no wait
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign start_req = wr_en && paddr == `LDP_CTRL_OFF && pwdata[`LDP_CTRL_START];
    assign reset_req = wr_en && paddr == `LDP_CTRL_OFF && pwdata[`LDP_CTRL_RESET];

    // length range and 32-sample granularity checked at start
    // AW caps the stored length; the full range needs AW of 29
    assign setup_ok = len_r >= `LDP_LEN_MIN && len_r <= `LDP_LEN_MAX // R4
        && len_r[`LDP_GRAN_BITS-1:0] == '0 && pre_r[`LDP_GRAN_BITS-1:0] == '0 // R5
        && pre_r < len_r && len_r <= (32'h1 << AW) && loaded_r; // R1

    // unmapped offsets answer with an error and read as zero
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            case (paddr)
                `LDP_CTRL_OFF, `LDP_LEN_OFF, `LDP_PRE_OFF, `LDP_ADDR_OFF,
                `LDP_DATA_OFF, `LDP_STAT_OFF, `LDP_ISR_OFF, `LDP_IMR_OFF,
                `LDP_LOOPS_OFF: pslverr = 1'b0;
                default: pslverr = 1'b1;
            endcase
        end
    end

    // configuration registers
    // write LEN before loading: the loaded flag compares against it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= '0;
            len_r <= `LDP_LEN_MIN;
            pre_r <= '0;
            imr_r <= '0;
        end else if (wr_en) begin
            case (paddr)
                `LDP_CTRL_OFF: begin
                    cfg_r.offbin <= pwdata[`LDP_CTRL_OFFBIN]; // R10
                    cfg_r.nch <= pwdata[`LDP_CTRL_NCH_HI:`LDP_CTRL_NCH_LO]; // R9
                end
                `LDP_LEN_OFF: len_r <= pwdata;
                `LDP_PRE_OFF: pre_r <= pwdata; // R5
                `LDP_IMR_OFF: imr_r <= pwdata[2:0];
                default: begin
                end
            endcase
        end
    end

    // host download: samples packed into rows by channel count
    // channel code 2 is unused and packs like one channel
    assign wrow = {wstage_r[3], wstage_r[2], wstage_r[1], wstage_r[0]};
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            waddr_r <= '0;
            wlane_r <= '0;
            loaded_r <= 1'b0;
            mem_we <= 1'b0;
            for (int i = 0; i < LANES; i++) begin
                wstage_r[i] <= '0;
            end
        end else begin
            mem_we <= 1'b0;
            if (wr_en && paddr == `LDP_ADDR_OFF) begin
                waddr_r <= pwdata;
                wlane_r <= '0;
                loaded_r <= 1'b0; // R1
            end else if (wr_en && paddr == `LDP_DATA_OFF && state_r == ldp_pkg::ST_IDLE) begin
                wstage_r[wlane_r] <= pwdata[RES-1:0]; // R9
                if (wlane_r == cfg_r.nch || cfg_r.nch == 2'd2) begin
                    wlane_r <= '0;
                    mem_we <= 1'b1;
                end else begin
                    wlane_r <= wlane_r + 2'd1;
                end
            end else if (mem_we) begin
                waddr_r <= waddr_r + 32'd1;
                loaded_r <= (waddr_r + 32'd1) == len_r; // R1
            end
        end
    end

    ldp_mem #(.AW(AW), .DW(DW)) u_mem (
        .clock(clock),
        .we(mem_we),
        .waddr(waddr_r[AW-1:0]),
        .wdata(wrow),
        .re(state_r == ldp_pkg::ST_PLAY && sample_en),
        .raddr(rd_idx_r[AW-1:0]),
        .rdata(mem_rdata)
    );

    // playback sequencer
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= ldp_pkg::ST_IDLE;
            rd_idx_r <= '0;
            loops_r <= '0;
        end else begin
            case (state_r)
                ldp_pkg::ST_IDLE: begin
                    if (start_req && setup_ok && !reset_req) begin
                        state_r <= ldp_pkg::ST_PLAY; // R1
                        rd_idx_r <= '0;
                        loops_r <= '0;
                    end
                end
                ldp_pkg::ST_PLAY: begin
                    if (reset_req || start_req) begin
                        state_r <= ldp_pkg::ST_IDLE; // R3
                    end else if (sample_en) begin // R13
                        if (rd_idx_r == len_r - 32'd1) begin
                            rd_idx_r <= pre_r; // R2 R5
                            loops_r <= loops_r + 32'd1;
                        end else begin
                            rd_idx_r <= rd_idx_r + 32'd1;
                        end
                    end
                end
                default: state_r <= ldp_pkg::ST_IDLE;
            endcase
        end
    end

    // one process drives the whole event bundle
    always_comb begin
        evt.loop_mark = state_r == ldp_pkg::ST_PLAY && sample_en && !start_req
            && !reset_req && rd_idx_r == len_r - 32'd1; // R6
        evt.ovf = state_r == ldp_pkg::ST_PLAY && rvalid_r && sample_en && !lane_ready; // R12
        evt.badcfg = start_req && state_r == ldp_pkg::ST_IDLE && !setup_ok; // R1 R4
    end

    // memory read in flight once strobed in play
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rvalid_r <= 1'b0;
        end else if (state_r != ldp_pkg::ST_PLAY) begin
            rvalid_r <= 1'b0;
        end else if (sample_en) begin // R13
            rvalid_r <= !start_req && !reset_req;
        end
    end

    // output lanes with format coding; data held until the next sample
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lane_data <= '0;
        end else if (state_r != ldp_pkg::ST_PLAY) begin
            lane_data <= '0;
        end else if (rvalid_r && sample_en) begin
            for (int i = 0; i < LANES; i++) begin
                lane_data[i*RES +: RES] <= mem_rdata[i*RES +: RES]
                    ^ {cfg_r.offbin, {(RES-1){1'b0}}}; // R10
            end
        end
    end

    // valid rises with the first real word, never over a stale register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lane_valid <= 1'b0;
        end else if (state_r != ldp_pkg::ST_PLAY) begin
            lane_valid <= 1'b0;
        end else if (rvalid_r && sample_en) begin
            lane_valid <= 1'b1; // R9
        end
    end

    // overflow: converter not ready when a sample is due
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ovf_r <= 1'b0;
        end else if (evt.ovf) begin
            ovf_r <= 1'b1; // R12
        end else if (reset_req) begin
            ovf_r <= 1'b0;
        end
    end
    assign board_indicator_lamp = ovf_r; // R12

    // marker pulse, 8 sample cycles
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mark_cnt_r <= '0;
        end else if (state_r != ldp_pkg::ST_PLAY) begin
            mark_cnt_r <= '0;
        end else if (evt.loop_mark) begin
            mark_cnt_r <= `LDP_MARK_CYC; // R6
        end else if (sample_en && mark_cnt_r != 4'h0) begin
            mark_cnt_r <= mark_cnt_r - 4'h1; // R6
        end
    end
    assign loop_restart_marker = mark_cnt_r != 4'h0;

    // free-running divide by 16 on sample enables
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_cnt_r <= '0;
        end else if (sample_en) begin
            div_cnt_r <= div_cnt_r + 4'h1; // R7 R13
        end
    end
    assign sample_rate_div_clock = div_cnt_r[3]; // R7

    // sticky events, cleared by reading; a new event wins over the clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            isr_r <= '0;
        end else begin
            // clear only what the read reported, so an event at the setup edge survives
            isr_r <= ((rd_en && paddr == `LDP_ISR_OFF) ? (isr_r & ~prdata[2:0]) : isr_r)
                | {evt.badcfg, evt.ovf, evt.loop_mark};
        end
    end
    assign irq = |(isr_r & imr_r);

    // read data latched in setup, standing through the access phase
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `LDP_CTRL_OFF: prdata <= {26'h0, cfg_r.nch, 1'b0, cfg_r.offbin, 2'b00};
                `LDP_LEN_OFF: prdata <= len_r;
                `LDP_PRE_OFF: prdata <= pre_r;
                `LDP_ADDR_OFF: prdata <= waddr_r;
                `LDP_STAT_OFF: prdata <= {29'h0, ovf_r, loaded_r, state_r == ldp_pkg::ST_PLAY};
                `LDP_ISR_OFF: prdata <= {29'h0, isr_r};
                `LDP_IMR_OFF: prdata <= {29'h0, imr_r};
                `LDP_LOOPS_OFF: prdata <= loops_r;
                default: prdata <= '0;
            endcase
        end
    end
endmodule

// ===== ldp_map.svh
`ifndef LDP_MAP_SVH
`define LDP_MAP_SVH

// register byte offsets
`define LDP_CTRL_OFF 12'h000
`define LDP_LEN_OFF 12'h004
`define LDP_PRE_OFF 12'h008
`define LDP_ADDR_OFF 12'h00c
`define LDP_DATA_OFF 12'h010
`define LDP_STAT_OFF 12'h014
`define LDP_ISR_OFF 12'h018
`define LDP_IMR_OFF 12'h01c
`define LDP_LOOPS_OFF 12'h020

// ctrl fields
`define LDP_CTRL_START 0
`define LDP_CTRL_RESET 1
`define LDP_CTRL_OFFBIN 2
`define LDP_CTRL_NCH_LO 4
`define LDP_CTRL_NCH_HI 5

// status / interrupt fields
`define LDP_ST_RUN 0
`define LDP_ST_LOADED 1
`define LDP_ST_OVF 2
`define LDP_IRQ_LOOP 0
`define LDP_IRQ_OVF 1
`define LDP_IRQ_BADCFG 2

// pattern limits and timing
`define LDP_LEN_MIN 32'h0000_1000
`define LDP_LEN_MAX 32'h2000_0000
`define LDP_GRAN_BITS 5
`define LDP_MARK_CYC 4'h8
`define LDP_DIV_HALF 3'h7

`endif

// ===== ldp_pkg.sv
package ldp_pkg;
    typedef enum {ST_IDLE, ST_PLAY} ldp_state_e;
    typedef struct packed {
        logic offbin;
        logic [1:0] nch;
    } ldp_cfg_s;
    typedef struct packed {
        logic loop_mark;
        logic ovf;
        logic badcfg;
    } ldp_evt_s;
endpackage

// ===== ldp_mem.sv
`timescale 1ns/1ps
module ldp_mem #(
    parameter int AW = 12,
    parameter int DW = 64
) (
    // clock
    input wire logic clock,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read port
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read, no reset on the array
    always_ff @(posedge clock) begin
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule

// ===== ldp_dac.sv
`timescale 1ns/1ps
module ldp_dac (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // test controls
    input wire logic slow,
    input wire logic stall,
    // to player
    output logic sample_en,
    output logic lane_ready
);
    logic [2:0] div_r;
    // a strobe, not a second clock, keeps the player single-domain
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_r <= 3'h0;
            sample_en <= 1'b0;
        end else begin
            div_r <= (div_r >= (slow ? 3'h4 : 3'h1)) ? 3'h0 : div_r + 3'h1;
            sample_en <= div_r == 3'h0;
        end
    end
    assign lane_ready = !stall;
endmodule

// ===== ldp_chk.sv
`timescale 1ns/1ps
module ldp_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // converter side
    input wire logic sample_en,
    input wire logic lane_ready,
    input wire logic lane_valid,
    input wire logic loop_restart_marker,
    input wire logic sample_rate_div_clock,
    input wire logic board_indicator_lamp
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic ctrl_wr;
    logic [3:0] se_cnt_r;
    logic [3:0] mk_cnt_r;
    assign ctrl_wr = psel && penable && pwrite && paddr == 12'h000;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) se_cnt_r <= 4'h0;
        else if (sample_en) se_cnt_r <= se_cnt_r + 4'h1;
    end
    // saturates so a stuck marker still fails
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) mk_cnt_r <= 4'h0;
        else if (!loop_restart_marker) mk_cnt_r <= 4'h0;
        else if (sample_en && mk_cnt_r != 4'hf) mk_cnt_r <= mk_cnt_r + 4'h1;
    end
    property p_div; sample_rate_div_clock == se_cnt_r[3]; endproperty
    a_div: assert property (p_div) else $error("aux clock off");
    property p_mk_max; loop_restart_marker |-> mk_cnt_r <= 4'h8; endproperty
    a_mk_max: assert property (p_mk_max) else $error("marker too long");
    property p_mk_len; $fell(loop_restart_marker) && lane_valid |-> mk_cnt_r == 4'h8;
    endproperty
    a_mk_len: assert property (p_mk_len) else $error("marker too short");
    property p_mk_src; $rose(loop_restart_marker) |-> $past(sample_en) && lane_valid;
    endproperty
    a_mk_src: assert property (p_mk_src) else $error("marker off strobe");
    property p_vld_src; $rose(lane_valid) |-> $past(sample_en); endproperty
    a_vld_src: assert property (p_vld_src) else $error("valid off strobe");
    property p_keep; lane_valid && !ctrl_wr && !$past(ctrl_wr) |=> lane_valid; endproperty
    a_keep: assert property (p_keep) else $error("playback dropped");
    property p_halt; ctrl_wr && pwdata[1] |-> ##[1:4] !lane_valid; endproperty
    a_halt: assert property (p_halt) else $error("reset did not halt");
    property p_ovf; sample_en && lane_valid && !lane_ready |-> ##[1:2] board_indicator_lamp;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow unflagged");
    property p_lamp; board_indicator_lamp && !ctrl_wr |=> board_indicator_lamp; endproperty
    a_lamp: assert property (p_lamp) else $error("lamp not sticky");
endmodule
bind ldp_player ldp_chk u_chk (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sample_en(sample_en),
    .lane_ready(lane_ready), .lane_valid(lane_valid), .loop_restart_marker(loop_restart_marker),
    .sample_rate_div_clock(sample_rate_div_clock), .board_indicator_lamp(board_indicator_lamp));

// ===== testbench.sv
`timescale 1ns/1ps
`include "ldp_map.svh"
module testbench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic slow = 1'b0;
    logic stall = 1'b0;
    logic [31:0] prdata, rd, v;
    logic pready, pslverr, err, sample_en, lane_ready, lane_valid, marker, divclk, lamp, irq;
    logic [63:0] lane_data;
    logic se_q = 1'b0;
    logic [31:0] mem[$];
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    int loops = 0;
    int k = 0;
    int pre = 32;
    bit mon = 0;
    bit run = 0;
    logic [31:0] cod = 32'h8000_8000;
    ldp_player u_dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_en(sample_en), .lane_ready(lane_ready),
        .lane_data(lane_data), .lane_valid(lane_valid), .loop_restart_marker(marker),
        .sample_rate_div_clock(divclk), .board_indicator_lamp(lamp), .irq(irq));
    ldp_dac u_dac (.clock(clock), .rstn(rstn), .slow(slow), .stall(stall),
        .sample_en(sample_en), .lane_ready(lane_ready));
    always #5 clock = ~clock;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic complete_run;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ceiling well above load plus two loops plus slow run
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            complete_run;
        end
    end
    // reference walk: row 0 up to the end, then back to the preamble point
    always @(posedge clock) se_q <= sample_en;
    always @(negedge clock) begin
        if (!lane_valid) run = 0;
        else if (mon) begin
            if (!run) begin
                run = 1;
                k = 0;
            end else if (se_q) begin
                if (k == 4095) begin
                    k = pre;
                    loops++;
                end else k++;
            end
            chk(lane_data[31:0], mem[k] ^ cod);
            chk(lane_data[63:32], cod);
        end
    end
    initial begin
        void'($urandom(32'hdeed05d7));
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rdc(`LDP_LEN_OFF, 32'h0000_1000);
        rdc(`LDP_CTRL_OFF, 32'h0);
        rdc(12'h024, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, `LDP_IMR_OFF, 32'h7);
        apb(1'b1, `LDP_CTRL_OFF, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rdc(`LDP_ISR_OFF, 32'h4);
        rdc(`LDP_STAT_OFF, 32'h0);
        apb(1'b1, `LDP_CTRL_OFF, 32'h14);
        apb(1'b1, `LDP_ADDR_OFF, 32'h0);
        // full signed 16-bit range, host scaling of one
        for (int i = 0; i < 4096; i++) begin
            v = $urandom;
            mem.push_back(v);
            apb(1'b1, `LDP_DATA_OFF, {16'h0, v[15:0]});
            apb(1'b1, `LDP_DATA_OFF, {16'h0, v[31:16]});
        end
        rdc(`LDP_STAT_OFF, 32'h2);
        apb(1'b1, `LDP_PRE_OFF, 32'h20);
        // length below the minimum must be refused
        apb(1'b1, `LDP_LEN_OFF, 32'h0000_0fe0);
        apb(1'b1, `LDP_CTRL_OFF, 32'h15);
        rdc(`LDP_ISR_OFF, 32'h4);
        apb(1'b1, `LDP_LEN_OFF, 32'h0000_1000);
        mon = 1;
        apb(1'b1, `LDP_CTRL_OFF, 32'h15);
        while (loops < 2) @(posedge clock);
        chk({31'h0, irq}, 32'h1);
        rdc(`LDP_ISR_OFF, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rdc(`LDP_STAT_OFF, 32'h3);
        mon = 0;
        apb(1'b1, `LDP_CTRL_OFF, 32'h15);
        for (int i = 0; i < 20 && lane_valid; i++) @(posedge clock);
        rdc(`LDP_STAT_OFF, 32'h2);
        // two's complement run at the slow rate
        slow <= 1'b1;
        cod = 32'h0;
        mon = 1;
        apb(1'b1, `LDP_CTRL_OFF, 32'h11);
        repeat (300) @(posedge clock);
        mon = 0;
        stall <= 1'b1;
        repeat (10) @(posedge clock);
        stall <= 1'b0;
        @(posedge clock);
        chk({31'h0, lamp}, 32'h1);
        rdc(`LDP_STAT_OFF, 32'h7);
        apb(1'b0, `LDP_ISR_OFF, 32'h0);
        chk({31'h0, rd[1]}, 32'h1);
        apb(1'b1, `LDP_CTRL_OFF, 32'h16);
        for (int i = 0; i < 20 && lane_valid; i++) @(posedge clock);
        chk({31'h0, lane_valid}, 32'h0);
        chk({31'h0, lamp}, 32'h0);
        chk(lane_data[31:0], 32'h0);
        complete_run;
    end
endmodule
